/* common/perb_pkg.sv */
// Purpose: Shared constants and types for the pace edge record buffer.
// Assumes: Master clock at 125 MHz and a separate serial clock.
// Notes:   Register index = address byte, 7-bit address, read bit last.
//
// Function
// - Groups fill in turn, wrapping after six.
// - Edges stored in order; only six kept.
// - Filled subgroup unread; empty second half all ones.
// - Empty subgroup all ones, flagged read.
// - Group read once all unread subgroups read.
// - Single read flags register on edge 32.
// - Burst flags A, B, C on 32, 56, 80.
// - Burst past edge 80 returns all ones.
// - Captured edge set raises new pace status.
// - Write over unread group raises overflow status.
// - Ten-bit timing field, default all ones.
// - Polarity bit, one means rising, default one.
// - Last edge bit, one means last or empty.
// - Sample tag names group holding its edges.
// - Groups at 0x30 to 0x47, four addresses each.
// - Two twelve-bit records per 24-bit subgroup.

package perb_pkg;

  // ****************************************
  // Sizes and layout
  // ****************************************
  localparam int NUM_GROUPS = 6;
  localparam int NUM_SUBS   = 3;
  localparam int NUM_WORDS  = 18;
  localparam int NUM_EDGES  = 6;
  localparam int WORD_W     = 24;
  localparam int REC_W      = 12;
  localparam int TIME_W     = 10;
  localparam int TIME_LSB   = 2;
  localparam int POL_BIT    = 1;
  localparam int LAST_BIT   = 0;
  localparam int HI_REC_LSB = 12;

  // ****************************************
  // Reset values and codes
  // ****************************************
  localparam logic [11:0] REC_EMPTY  = 12'hFFF;
  localparam logic [23:0] WORD_EMPTY = 24'hFFFFFF;
  localparam logic [2:0]  TAG_NONE   = 3'h7;
  localparam logic [2:0]  LAST_GROUP = 3'h5;
  localparam logic [6:0]  ADDR_FIRST = 7'h30;
  localparam logic [6:0]  ADDR_LAST  = 7'h47;

  // ****************************************
  // Serial frame edge counts
  // ****************************************
  localparam logic [6:0] CMD_BITS   = 7'h08;
  localparam logic [6:0] END_SUB_A  = 7'h1F;
  localparam logic [6:0] END_SUB_B  = 7'h37;
  localparam logic [6:0] END_SUB_C  = 7'h4F;
  localparam logic [6:0] CNT_MAX    = 7'h7F;

  typedef logic [23:0] perb_word_t;
  typedef enum {PERB_SP_CMD, PERB_SP_SINGLE, PERB_SP_BURST,
                PERB_SP_IGNORE} perb_sp_state_t;

endpackage : perb_pkg

/* hw/perb_serial_port.sv */
// Purpose: Serial read port for the pace subgroup registers.
// Assumes: Data shifts out on falling edges, MSB first.
// Notes:   The snapshot input is frozen while the frame is active.
`timescale 1ns/10ps

module perb_serial_port (
  input  wire logic                   sclk_i,
  input  wire logic                   csb_i,
  input  wire logic                   reset_i,
  input  wire logic                   sdi_i,
  input  wire perb_pkg::perb_word_t   snap_i [perb_pkg::NUM_WORDS],
  output logic                        sdo_o,
  output logic                        mark_toggle_o,
  output logic [4:0]                  mark_idx_o
);

  perb_pkg::perb_sp_state_t state;
  logic [6:0] cnt;
  logic [7:0] cmd;
  logic [7:0] next_cmd;
  logic [6:0] offset;
  logic [2:0] group;
  logic [1:0] sub;
  logic [1:0] cur_sub;
  logic [6:0] last_cnt;
  logic       word_valid;
  logic       filler;
  logic [4:0] cur_idx;
  logic [6:0] bit_pos;

  // ****************************************
  // Command capture
  // ****************************************
  assign next_cmd = {cmd[6:0], sdi_i};
  assign offset   = next_cmd[7:1] - perb_pkg::ADDR_FIRST;

  // Chip select high ends the frame even though the serial clock is stopped.
  always_ff @(posedge sclk_i or posedge csb_i) begin
    if (csb_i) begin
      cnt   <= 7'h00;
      cmd   <= 8'h00;
      state <= perb_pkg::PERB_SP_CMD;
      group <= 3'h0;
      sub   <= 2'h0;
    end else begin
      if (cnt != perb_pkg::CNT_MAX) begin
        cnt <= cnt + 7'h01;
      end
      if (cnt < perb_pkg::CMD_BITS) begin
        cmd <= next_cmd;
      end
      if (cnt == perb_pkg::CMD_BITS - 7'h01) begin
        group <= offset[4:2];
        sub   <= offset[1:0];
        if (next_cmd[7:1] >= perb_pkg::ADDR_FIRST &&
            next_cmd[7:1] <= perb_pkg::ADDR_LAST && next_cmd[0]) begin
          if (offset[1:0] == 2'h0) begin
            state <= perb_pkg::PERB_SP_BURST;
          end else begin
            state <= perb_pkg::PERB_SP_SINGLE;
          end
        end else begin
          state <= perb_pkg::PERB_SP_IGNORE;
        end
      end
    end
  end

  // ****************************************
  // Word selection
  // ****************************************
  always_comb begin
    word_valid = 1'b0;
    filler     = 1'b0;
    cur_sub    = 2'h0;
    last_cnt   = perb_pkg::END_SUB_A;
    case (state)
      perb_pkg::PERB_SP_SINGLE: begin
        cur_sub    = sub - 2'h1;
        word_valid = cnt <= perb_pkg::END_SUB_A;
        filler     = !word_valid;
      end
      perb_pkg::PERB_SP_BURST: begin
        word_valid = 1'b1;
        if (cnt <= perb_pkg::END_SUB_A) begin
          cur_sub = 2'h0;
        end else if (cnt <= perb_pkg::END_SUB_B) begin
          cur_sub  = 2'h1;
          last_cnt = perb_pkg::END_SUB_B;
        end else if (cnt <= perb_pkg::END_SUB_C) begin
          cur_sub  = 2'h2;
          last_cnt = perb_pkg::END_SUB_C;
        end else begin
          word_valid = 1'b0;
          filler     = 1'b1;
        end
      end
      default: begin
        word_valid = 1'b0;
      end
    endcase
  end

  assign cur_idx = 5'(group * 3) + 5'(cur_sub);
  assign bit_pos = last_cnt - cnt;

  // ****************************************
  // Serial output and read marking
  // ****************************************
  always_ff @(negedge sclk_i or posedge csb_i or posedge reset_i) begin
    if (csb_i || reset_i) begin
      sdo_o <= 1'b0;
    end else if (filler) begin
      sdo_o <= 1'b1;
    end else if (word_valid && cnt >= perb_pkg::CMD_BITS) begin
      sdo_o <= snap_i[cur_idx][bit_pos[4:0]];
    end else begin
      sdo_o <= 1'b0;
    end
  end

  // The index is held until the next mark so the far side can sample it.
  always_ff @(posedge sclk_i or posedge reset_i) begin
    if (reset_i) begin
      mark_toggle_o <= 1'b0;
      mark_idx_o    <= 5'h00;
    end else if (!csb_i && word_valid && cnt == last_cnt) begin
      mark_toggle_o <= !mark_toggle_o;
      mark_idx_o    <= cur_idx;
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  a_single_mark: assert property (@(posedge sclk_i) disable iff (csb_i)
    state == perb_pkg::PERB_SP_SINGLE && cnt == 7'h1F
    |=> mark_toggle_o != $past(mark_toggle_o))
    else $error("single read not marked on edge 32");

  a_burst_mark_c: assert property (@(posedge sclk_i) disable iff (csb_i)
    state == perb_pkg::PERB_SP_BURST && cnt == 7'h4F
    |=> mark_toggle_o != $past(mark_toggle_o) && mark_idx_o == group * 3 + 2)
    else $error("burst subgroup C not marked on edge 80");

  a_burst_filler: assert property (@(posedge sclk_i) disable iff (csb_i)
    state == perb_pkg::PERB_SP_BURST && cnt >= 7'h50 |-> sdo_o)
    else $error("burst past edge 80 not all ones");

  c_burst_end: cover property (@(posedge sclk_i) disable iff (csb_i)
    state == perb_pkg::PERB_SP_BURST && cnt == 7'h50);

endmodule : perb_serial_port

/* hw/perb_pace_buffer.sv */
// Purpose: Pace edge record buffer with six groups and serial readout.
// Assumes: Edge and sample strobes are one-cycle pulses on clk_i.
// Notes:   Records cross to the serial side through a frozen snapshot.
`timescale 1ns/10ps

module perb_pace_buffer (
  input  wire logic        clk_i,
  input  wire logic        reset_i,
  input  wire logic        edge_detect_i,
  input  wire logic        edge_polarity_bit_i,
  input  wire logic [9:0]  edge_timing_field_i,
  input  wire logic        sample_strobe_i,
  input  wire logic        resync_command_i,
  input  wire logic        fifo_reset_i,
  input  wire logic        new_pace_clear_i,
  input  wire logic        sclk_i,
  input  wire logic        csb_i,
  input  wire logic        sdi_i,
  output logic             sdo_o,
  output logic [2:0]       sample_group_tag_o,
  output logic             new_pace_irq_status_o,
  output logic             pace_overflow_status_o,
  output logic [5:0]       group_unread_o
);

  logic [5:0][11:0]      stage_rec;
  logic [2:0]            stage_cnt;
  logic [11:0]           new_rec;
  logic                  flush;
  logic                  commit;
  logic [2:0]            wptr;
  logic [2:0][23:0]      commit_word;
  logic [2:0]            commit_fill;
  perb_pkg::perb_word_t  store [perb_pkg::NUM_WORDS];
  perb_pkg::perb_word_t  snap  [perb_pkg::NUM_WORDS];
  logic [17:0]           unread;
  logic                  csb_sync1;
  logic                  csb_sync2;
  logic                  mark_sync1;
  logic                  mark_sync2;
  logic                  mark_seen;
  logic                  mark_evt;
  logic                  mark_toggle;
  logic [4:0]            mark_idx;

  // ****************************************
  // Edge staging between samples
  // ****************************************
  assign flush   = resync_command_i || fifo_reset_i;
  assign commit  = sample_strobe_i && stage_cnt != 3'h0 && !flush;
  assign new_rec = {edge_timing_field_i, edge_polarity_bit_i, 1'b1};

  // An edge that coincides with a sample belongs to the next interval.
  always_ff @(posedge clk_i) begin
    if (reset_i || flush) begin
      stage_cnt <= 3'h0;
      stage_rec <= {6{perb_pkg::REC_EMPTY}};
    end else if (sample_strobe_i) begin
      stage_cnt    <= edge_detect_i ? 3'h1 : 3'h0;
      stage_rec[0] <= new_rec;
    end else if (edge_detect_i &&
                 stage_cnt < 3'(perb_pkg::NUM_EDGES)) begin
      stage_rec[stage_cnt] <= new_rec;
      stage_cnt            <= stage_cnt + 3'h1;
      if (stage_cnt != 3'h0) begin
        stage_rec[stage_cnt - 3'h1][perb_pkg::LAST_BIT] <= 1'b0;
      end
    end
  end

  // ****************************************
  // Subgroup words for the group being written
  // ****************************************
  for (genvar s = 0; s < perb_pkg::NUM_SUBS; s++) begin : g_word
    localparam logic [2:0] LO = 3'(2 * s);
    localparam logic [2:0] HI = 3'(2 * s + 1);
    assign commit_fill[s] = stage_cnt > LO;
    assign commit_word[s][23:perb_pkg::HI_REC_LSB] =
      stage_cnt > LO ? stage_rec[LO] : perb_pkg::REC_EMPTY;
    assign commit_word[s][perb_pkg::HI_REC_LSB-1:0] =
      stage_cnt > HI ? stage_rec[HI] : perb_pkg::REC_EMPTY;
  end

  // ****************************************
  // Group write pointer and status
  // ****************************************
  always_ff @(posedge clk_i) begin
    if (reset_i || flush) begin
      wptr <= 3'h0;
    end else if (commit) begin
      wptr <= wptr == perb_pkg::LAST_GROUP ? 3'h0 : wptr + 3'h1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      sample_group_tag_o <= perb_pkg::TAG_NONE;
    end else if (sample_strobe_i) begin
      sample_group_tag_o <= commit ? wptr : perb_pkg::TAG_NONE;
    end
  end

  // A new capture in the clearing cycle keeps the flag raised.
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      new_pace_irq_status_o <= 1'b0;
    end else if (commit) begin
      new_pace_irq_status_o <= 1'b1;
    end else if (new_pace_clear_i) begin
      new_pace_irq_status_o <= 1'b0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (reset_i || flush) begin
      pace_overflow_status_o <= 1'b0;
    end else if (commit && group_unread_o[wptr]) begin
      pace_overflow_status_o <= 1'b1;
    end
  end

  // ****************************************
  // Record storage and read flags
  // ****************************************
  for (genvar i = 0; i < perb_pkg::NUM_WORDS; i++) begin : g_store
    localparam logic [2:0] GRP = 3'(i / 3);
    localparam int         SUB = i % 3;
    // A write to the entry wins over a read mark in the same cycle.
    always_ff @(posedge clk_i) begin
      if (reset_i || flush) begin
        store[i]  <= perb_pkg::WORD_EMPTY;
        unread[i] <= 1'b0;
      end else if (commit && wptr == GRP) begin
        store[i]  <= commit_word[SUB];
        unread[i] <= commit_fill[SUB];
      end else if (mark_evt && mark_idx == 5'(i)) begin
        unread[i] <= 1'b0;
      end
    end
  end

  for (genvar g = 0; g < perb_pkg::NUM_GROUPS; g++) begin : g_group
    assign group_unread_o[g] = |unread[3*g +: 3];
  end

  // ****************************************
  // Crossings with the serial clock domain
  // ****************************************
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      csb_sync1  <= 1'b1;
      csb_sync2  <= 1'b1;
      mark_sync1 <= 1'b0;
      mark_sync2 <= 1'b0;
      mark_seen  <= 1'b0;
    end else begin
      csb_sync1  <= csb_i;
      csb_sync2  <= csb_sync1;
      mark_sync1 <= mark_toggle;
      mark_sync2 <= mark_sync1;
      mark_seen  <= mark_sync2;
    end
  end

  // The index settles long before its toggle clears the synchroniser.
  assign mark_evt = mark_sync2 ^ mark_seen;

  // Frozen while a frame runs; the first data bit follows eight clocks.
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      snap <= '{default: perb_pkg::WORD_EMPTY};
    end else if (csb_sync2) begin
      snap <= store;
    end
  end

  perb_serial_port u_port (
    .sclk_i        (sclk_i),
    .csb_i         (csb_i),
    .reset_i       (reset_i),
    .sdi_i         (sdi_i),
    .snap_i        (snap),
    .sdo_o         (sdo_o),
    .mark_toggle_o (mark_toggle),
    .mark_idx_o    (mark_idx)
  );

  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (reset_i);

  a_ptr_wrap: assert property (
    commit && wptr == 3'h5 |=> wptr == 3'h0)
    else $error("group pointer did not wrap to zero");

  a_ptr_step: assert property (
    commit && wptr != 3'h5 |=> wptr == $past(wptr) + 3'h1)
    else $error("group pointer did not advance");

  a_stage_cap: assert property (
    stage_cnt == 3'h6 && edge_detect_i && !sample_strobe_i && !flush
    |=> stage_cnt == 3'h6 && $stable(stage_rec))
    else $error("seventh edge was stored");

  a_half_fill: assert property (
    commit && stage_cnt == 3'h1
    |=> store[$past(wptr) * 3][11:0] == 12'hFFF && unread[$past(wptr) * 3])
    else $error("half-filled subgroup wrong");

  a_empty_sub: assert property (
    commit && stage_cnt <= 3'h4
    |=> store[$past(wptr) * 3 + 2] == 24'hFFFFFF
        && !unread[$past(wptr) * 3 + 2])
    else $error("empty subgroup not defaulted or read");

  a_last_flag: assert property (
    commit && stage_cnt == 3'h2
    |=> store[$past(wptr) * 3][12] == 1'b0
        && store[$past(wptr) * 3][0] == 1'b1)
    else $error("last edge bits wrong");

  a_mark_clear: assert property (
    mark_evt && !commit ##1 1'b1 |-> !unread[$past(mark_idx)])
    else $error("read mark did not clear flag");

  a_new_pace: assert property (
    commit |=> new_pace_irq_status_o)
    else $error("new pace status not raised");

  a_overflow: assert property (
    commit && group_unread_o[wptr] |=> pace_overflow_status_o)
    else $error("overflow not flagged");

  a_tag_link: assert property (
    commit |=> sample_group_tag_o == $past(wptr))
    else $error("sample tag does not name group");

  a_flush_all: assert property (
    flush |=> wptr == 3'h0 && unread == 18'h00000
              && !pace_overflow_status_o)
    else $error("resync did not restore defaults");

  c_wrap: cover property (commit && wptr == 3'h5);
  c_overflow: cover property (commit && group_unread_o[wptr]);
  c_six_edges: cover property (commit && stage_cnt == 3'h6);
  c_mark: cover property (mark_evt);

endmodule : perb_pace_buffer

/* bench/perb_serial_host.sv */
// Purpose: Serial host model that reads the pace subgroup registers.
// Assumes: Serial clock idles low and runs only inside a frame.
// Notes:   Data bits are sampled on rising edges after the command byte.
`timescale 1ns/10ps

module perb_serial_host (
  input  wire logic sdo_i,
  output logic      sclk_o,
  output logic      csb_o,
  output logic      sdi_o
);

  initial begin
    sclk_o = 1'h0;
    csb_o  = 1'h1;
    sdi_o  = 1'h0;
  end

  // ****************************************
  // One frame of nedge serial clock edges
  // ****************************************
  task automatic xfer(input logic [7:0] cmd, input int nedge,
                      output logic [87:0] rx);
    rx = '0;
    csb_o = 1'h0;
    #20;
    for (int i = 1; i <= nedge; i++) begin
      // Beyond the command the line toggles so no stale bit is reused.
      sdi_o = (i <= 8) ? cmd[8-i] : ~sdi_o;
      #7.5 sclk_o = 1'h1;
      if (i > 8) rx = {rx[86:0], sdo_i};
      #7.5 sclk_o = 1'h0;
    end
    #10 csb_o = 1'h1;
    sdi_o = ~sdi_o;
    // The gap lets the master side refresh its snapshot between frames.
    #40;
  endtask : xfer

endmodule : perb_serial_host

/* bench/perb_pace_buffer_tb.sv */
// Purpose: Self-checking bench for the pace edge record buffer.
// Assumes: Strobes are driven on falling edges of the master clock.
// Notes:   Expected words are built from edge counts and timing bases.
`timescale 1ns/10ps

module perb_pace_buffer_tb;

  logic        clk_i = 1'h0;
  logic        reset_i = 1'h1;
  logic        edge_detect_i = 1'h0;
  logic        edge_polarity_bit_i = 1'h0;
  logic [9:0]  edge_timing_field_i = 10'h000;
  logic        sample_strobe_i = 1'h0;
  logic        resync_command_i = 1'h0;
  logic        fifo_reset_i = 1'h0;
  logic        new_pace_clear_i = 1'h0;
  logic        sclk_i;
  logic        csb_i;
  logic        sdi_i;
  logic        sdo_o;
  logic [2:0]  sample_group_tag_o;
  logic        new_pace_irq_status_o;
  logic        pace_overflow_status_o;
  logic [5:0]  group_unread_o;
  logic [87:0] rx;
  int          errors = 0;
  int          n_tests = 0;

  always #4 clk_i = ~clk_i;

  perb_pace_buffer perb_pace_buffer_inst (
    .clk_i(clk_i), .reset_i(reset_i), .edge_detect_i(edge_detect_i),
    .edge_polarity_bit_i(edge_polarity_bit_i),
    .edge_timing_field_i(edge_timing_field_i),
    .sample_strobe_i(sample_strobe_i),
    .resync_command_i(resync_command_i), .fifo_reset_i(fifo_reset_i),
    .new_pace_clear_i(new_pace_clear_i), .sclk_i(sclk_i), .csb_i(csb_i),
    .sdi_i(sdi_i), .sdo_o(sdo_o), .sample_group_tag_o(sample_group_tag_o),
    .new_pace_irq_status_o(new_pace_irq_status_o),
    .pace_overflow_status_o(pace_overflow_status_o),
    .group_unread_o(group_unread_o));

  perb_serial_host perb_serial_host_inst (
    .sdo_i(sdo_o), .sclk_o(sclk_i), .csb_o(csb_i), .sdi_o(sdi_i));

  // ****************************************
  // Checking and reporting
  // ****************************************
  task automatic check(input string what, input logic [23:0] exp,
                       input logic [23:0] got);
    n_tests++;
    if (got !== exp) begin
      errors++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  task automatic give_verdict;
    $display("Comparisons %0d, mismatches %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : give_verdict

  task automatic stat(input logic [2:0] tag, input logic np,
                      input logic ov, input logic [5:0] un);
    check("status", {13'h0, tag, np, ov, un},
          {13'h0, sample_group_tag_o, new_pace_irq_status_o,
           pace_overflow_status_o, group_unread_o});
  endtask : stat

  // Edge k has timing base+8k, rising on even k; only six are kept.
  function automatic logic [23:0] exp_word(input int n,
                                           input logic [9:0] base,
                                           input int sub);
    logic [11:0] h [2];
    int k;
    int m;
    m = (n > 6) ? 6 : n;
    for (int j = 0; j < 2; j++) begin
      k = 2 * sub + j;
      h[j] = (k < m) ? {base + 10'(8 * k), ~k[0], k == m - 1} : 12'hFFF;
    end
    return {h[0], h[1]};
  endfunction : exp_word

  // ****************************************
  // Stimulus tasks
  // ****************************************
  task automatic capture(input int n, input logic [9:0] base);
    @(negedge clk_i);
    for (int k = 0; k < n; k++) begin
      edge_detect_i = 1'h1;
      edge_timing_field_i = base + 10'(8 * k);
      edge_polarity_bit_i = ~k[0];
      @(negedge clk_i);
    end
    edge_detect_i = 1'h0;
    sample_strobe_i = 1'h1;
    @(negedge clk_i);
    sample_strobe_i = 1'h0;
    repeat (2) @(negedge clk_i);
  endtask : capture

  task automatic pulse_cmd(input int which);
    @(negedge clk_i);
    resync_command_i = (which == 0);
    fifo_reset_i = (which == 1);
    new_pace_clear_i = (which == 2);
    @(negedge clk_i);
    resync_command_i = 1'h0;
    fifo_reset_i = 1'h0;
    new_pace_clear_i = 1'h0;
    repeat (2) @(negedge clk_i);
  endtask : pulse_cmd

  // Eight extra clocks run past the mark edge so the frame stays open
  // while the single-read mark is checked on the serial side.
  task automatic read_word(input string what, input logic [6:0] addr,
                           input logic [23:0] exp);
    perb_serial_host_inst.xfer({addr, 1'h1}, 40, rx);
    check(what, exp, rx[31:8]);
  endtask : read_word

  task automatic wait_unread(input int g, input logic exp);
    int i;
    i = 0;
    while (i < 20 && group_unread_o[g] !== exp) begin
      @(negedge clk_i);
      i++;
    end
    check("group unread", {23'h0, exp}, {23'h0, group_unread_o[g]});
    if (group_unread_o[g] !== exp) give_verdict();
  endtask : wait_unread

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    repeat (2) @(negedge clk_i);
    reset_i = 1'h0;
    stat(3'h7, 1'h0, 1'h0, 6'h00);
    read_word("empty subgroup", 7'h31, 24'hFFFFFF);
    read_word("past map", 7'h48, 24'h000000);
    read_word("below map", 7'h20, 24'h000000);
    $display("Test reset and map done");
    capture(2, 10'h100);
    stat(3'h0, 1'h1, 1'h0, 6'h01);
    read_word("group0 A", 7'h31, exp_word(2, 10'h100, 0));
    read_word("group0 B", 7'h32, 24'hFFFFFF);
    wait_unread(0, 1'h0);
    capture(3, 10'h040);
    stat(3'h1, 1'h1, 1'h0, 6'h02);
    read_word("group1 A", 7'h35, exp_word(3, 10'h040, 0));
    repeat (10) @(negedge clk_i);
    wait_unread(1, 1'h1);
    read_word("group1 B", 7'h36, exp_word(3, 10'h040, 1));
    wait_unread(1, 1'h0);
    $display("Test single reads done");
    capture(7, 10'h200);
    perb_serial_host_inst.xfer({7'h38, 1'h1}, 88, rx);
    check("burst A", exp_word(7, 10'h200, 0), rx[79:56]);
    check("burst B", exp_word(7, 10'h200, 1), rx[55:32]);
    check("burst C", exp_word(7, 10'h200, 2), rx[31:8]);
    check("burst filler", 24'h0000FF, {16'h0, rx[7:0]});
    wait_unread(2, 1'h0);
    capture(1, 10'h3F0);
    perb_serial_host_inst.xfer({7'h3C, 1'h1}, 32, rx);
    check("short burst", exp_word(1, 10'h3F0, 0), rx[23:0]);
    wait_unread(3, 1'h0);
    $display("Test bursts done");
    pulse_cmd(2);
    stat(3'h3, 1'h0, 1'h0, 6'h00);
    for (int k = 0; k <= 6; k++) begin
      capture(1, 10'(k));
      check("tag", {21'h0, 3'((4 + k) % 6)}, {21'h0, sample_group_tag_o});
      check("overflow", {23'h0, k == 6}, {23'h0, pace_overflow_status_o});
    end
    $display("Test wrap and overflow done");
    pulse_cmd(0);
    check("flush", 24'h0, {17'h0, pace_overflow_status_o, group_unread_o});
    read_word("flushed word", 7'h41, 24'hFFFFFF);
    capture(1, 10'h010);
    check("tag after resync", 24'h0, {21'h0, sample_group_tag_o});
    capture(1, 10'h020);
    pulse_cmd(1);
    capture(1, 10'h030);
    check("tag after reset", 24'h0, {21'h0, sample_group_tag_o});
    $display("Test resync done");
    give_verdict();
  end

endmodule : perb_pace_buffer_tb
